// >>> hdl/aclks_classify.sv
`timescale 1ns/100ps
module aclks_classify (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       take_i,
  input  wire logic [15:0] etype_i,
  input  wire logic [3:0] ip_ver_i,
  input  wire logic [7:0] dip_msb_i,
  input  wire logic [7:0] proto_i,
  input  wire logic [7:0] dsap_i,
  input  wire logic [7:0] ssap_i,
  input  wire logic [7:0] llc_ctrl_i,
  output logic            valid_o,
  output aclks_pkg::aclks_ftype_t ftype_o,
  output aclks_pkg::aclks_l4_t    l4_o
);

  typedef struct packed {
    logic                    valid;
    aclks_pkg::aclks_ftype_t ftype;
    aclks_pkg::aclks_l4_t    l4;
  } aclks_cls_t;

  aclks_cls_t q_ff;
  aclks_cls_t nxt_q;

  always_comb begin
    nxt_q       = q_ff;
    nxt_q.valid = take_i;
    if (take_i) begin
      // one type per frame; unmatched ethertypes fall back to generic
      if (etype_i < aclks_pkg::ET_LEN_MAX) begin
        if (dsap_i == aclks_pkg::SAP_SNAP && ssap_i == aclks_pkg::SAP_SNAP &&
            llc_ctrl_i == aclks_pkg::LLC_CTRL_UI) begin
          nxt_q.ftype = aclks_pkg::FT_SNAP;
        end else begin
          nxt_q.ftype = aclks_pkg::FT_LLC;
        end
      end else if (etype_i == aclks_pkg::ET_IPV6 && ip_ver_i == aclks_pkg::IPV6_VER) begin
        nxt_q.ftype = (dip_msb_i == aclks_pkg::V6_MC_BYTE) ? aclks_pkg::FT_IPV6_MC
                                                            : aclks_pkg::FT_IPV6_UC;
      end else if (etype_i == aclks_pkg::ET_IPV4 && ip_ver_i == aclks_pkg::IPV4_VER) begin
        nxt_q.ftype = (dip_msb_i[7:4] == aclks_pkg::V4_MC_NIB) ? aclks_pkg::FT_IPV4_MC
                                                                : aclks_pkg::FT_IPV4_UC;
      end else if (etype_i == aclks_pkg::ET_ARP || etype_i == aclks_pkg::ET_RARP) begin
        nxt_q.ftype = aclks_pkg::FT_ARP;
      end else if (etype_i == aclks_pkg::ET_OAM) begin
        nxt_q.ftype = aclks_pkg::FT_OAM;
      end else begin
        nxt_q.ftype = aclks_pkg::FT_ETYPE;
      end
      // next header for ipv6, protocol for ipv4
      if (proto_i == aclks_pkg::PROTO_TCP) begin
        nxt_q.l4 = aclks_pkg::L4_TCP;
      end else if (proto_i == aclks_pkg::PROTO_UDP) begin
        nxt_q.l4 = aclks_pkg::L4_UDP;
      end else begin
        nxt_q.l4 = aclks_pkg::L4_OTHER;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      q_ff <= '{valid: 1'b0, ftype: aclks_pkg::FT_ETYPE, l4: aclks_pkg::L4_OTHER};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign valid_o = q_ff.valid;
  assign ftype_o = q_ff.ftype;
  assign l4_o    = q_ff.l4;

endmodule

// >>> hdl/aclks_pkg.sv
package aclks_pkg;

  localparam int          NPORT       = 16;
  localparam int          PW          = 4;
  localparam int          NLKP        = 4;
  localparam int          LW          = 2;
  localparam int          ACTW        = 16;
  localparam int          CNTW        = 32;
  localparam int          OFSW        = 8;
  localparam int          AW          = 12;

  localparam logic [15:0] ET_IPV6     = 16'h86dd;
  localparam logic [15:0] ET_IPV4     = 16'h0800;
  localparam logic [15:0] ET_ARP      = 16'h0806;
  localparam logic [15:0] ET_RARP     = 16'h8035;
  localparam logic [15:0] ET_OAM      = 16'h8902;
  localparam logic [15:0] ET_LEN_MAX  = 16'h0600;
  localparam logic [3:0]  IPV6_VER    = 4'h6;
  localparam logic [3:0]  IPV4_VER    = 4'h4;
  localparam logic [7:0]  V6_MC_BYTE  = 8'hff;
  localparam logic [3:0]  V4_MC_NIB   = 4'he;
  localparam logic [7:0]  PROTO_TCP   = 8'h06;
  localparam logic [7:0]  PROTO_UDP   = 8'h11;
  localparam logic [7:0]  SAP_SNAP    = 8'haa;
  localparam logic [7:0]  LLC_CTRL_UI = 8'h03;

  localparam logic [AW-1:0] A_STATUS   = 12'h000;
  localparam logic [AW-1:0] A_HIT_BASE = 12'h010;
  localparam logic [AW-1:0] A_MISS_BASE = 12'h020;
  localparam logic [AW-1:0] A_DEF_BASE = 12'h030;
  localparam logic [AW-1:0] A_ENA_BASE = 12'h100;
  localparam logic [AW-1:0] A_KSEL_BASE = 12'h200;

  localparam logic [ACTW-1:0] DEF_ACT_RST = 16'h0000;
  localparam logic [NLKP-1:0] ENA_RST     = 4'h0;
  localparam logic [2:0]      KSEL_RST    = 3'h0;
  localparam int              KSEL_FW     = 4;
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    FT_IPV6_MC, FT_IPV6_UC, FT_IPV4_MC, FT_IPV4_UC, FT_ARP, FT_OAM, FT_SNAP, FT_LLC, FT_ETYPE
  } aclks_ftype_t;

  typedef enum logic [1:0] {L4_TCP, L4_UDP, L4_OTHER} aclks_l4_t;

  typedef enum logic [2:0] {
    KEY_GENERIC_L2, KEY_IPV6_VLAN, KEY_SEVEN_TUPLE, KEY_IPV4_L4,
    KEY_IPV4_MISC, KEY_IPV4_VLAN, KEY_ARP, KEY_CUSTOM
  } aclks_key_t;

endpackage

// >>> hdl/aclks_top.sv
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module aclks_top (
  input  wire logic                          clock_i,
  input  wire logic                          sys_rst_i,
  // frame from parser
  input  wire logic                          frm_valid_i,
  output logic                               frm_ready_o,
  input  wire logic [aclks_pkg::PW-1:0]      frm_port_i,
  input  wire logic [15:0]                   frm_etype_i,
  input  wire logic [3:0]                    frm_ip_ver_i,
  input  wire logic [7:0]                    frm_dip_msb_i,
  input  wire logic [7:0]                    frm_proto_i,
  input  wire logic [7:0]                    frm_dsap_i,
  input  wire logic [7:0]                    frm_ssap_i,
  input  wire logic [7:0]                    frm_llc_ctrl_i,
  input  wire logic                          frm_custom_i,
  input  wire logic [aclks_pkg::OFSW-1:0]    frm_custom_ofs_i,
  // key request to the security match table
  output logic                               key_valid_o,
  output logic [aclks_pkg::LW-1:0]           key_lookup_o,
  output logic [2:0]                         key_type_o,
  output logic [3:0]                         key_frame_type_o,
  output logic [1:0]                         key_l4_o,
  output logic [aclks_pkg::PW-1:0]           key_port_o,
  output logic [aclks_pkg::OFSW-1:0]         key_custom_ofs_o,
  // match result
  input  wire logic                          res_valid_i,
  input  wire logic                          res_hit_i,
  input  wire logic [aclks_pkg::ACTW-1:0]    res_action_i,
  // assigned action
  output logic                               act_valid_o,
  output logic [aclks_pkg::LW-1:0]           act_lookup_o,
  output logic                               act_hit_o,
  output logic [aclks_pkg::ACTW-1:0]         act_action_o,
  // axi4-lite slave
  input  wire logic [aclks_pkg::AW-1:0]      s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [aclks_pkg::AW-1:0]      s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);

  typedef enum logic [1:0] {ST_IDLE, ST_CLASS, ST_KEY, ST_WAIT} aclks_st_t;

  typedef struct packed {
    aclks_st_t                                          st;
    logic [aclks_pkg::LW-1:0]                           lkp;
    logic [aclks_pkg::PW-1:0]                           port;
    logic                                               cust;
    logic [aclks_pkg::OFSW-1:0]                         ofs;
    aclks_pkg::aclks_ftype_t                            ftype;
    aclks_pkg::aclks_l4_t                               l4;
    logic                                               frm_rdy;
    logic                                               key_vld;
    logic [2:0]                                         key_type;
    logic                                               act_vld;
    logic                                               act_hit;
    logic [aclks_pkg::ACTW-1:0]                         act;
    logic [aclks_pkg::LW-1:0]                           act_lkp;
    logic [aclks_pkg::NPORT-1:0][aclks_pkg::NLKP-1:0]   ena;
    logic [aclks_pkg::NPORT-1:0][aclks_pkg::NLKP-1:0][2:0] ksel;
    logic [aclks_pkg::NLKP-1:0][aclks_pkg::ACTW-1:0]    def_act;
    logic [aclks_pkg::NLKP-1:0][aclks_pkg::CNTW-1:0]    hits;
    logic [aclks_pkg::NLKP-1:0][aclks_pkg::CNTW-1:0]    miss;
    logic                                               aw_have;
    logic [aclks_pkg::AW-1:0]                           aw_addr;
    logic                                               w_have;
    logic [31:0]                                        w_data;
    logic [3:0]                                         w_strb;
    logic                                               aw_rdy;
    logic                                               w_rdy;
    logic                                               bvalid;
    logic [1:0]                                         bresp;
    logic                                               ar_rdy;
    logic                                               rvalid;
    logic [31:0]                                        rdata;
    logic [1:0]                                         rresp;
  } aclks_state_t;

  aclks_state_t            q_ff;
  aclks_state_t            nxt_q;
  logic                    take;
  logic                    cls_valid;
  aclks_pkg::aclks_ftype_t cls_ftype;
  aclks_pkg::aclks_l4_t    cls_l4;
  logic [31:0]             wword;
  logic [31:0]             rword;
  logic                    rhit;
  logic [aclks_pkg::AW-1:0] ra;
  logic [aclks_pkg::AW-1:0] wa;

  assign take = frm_valid_i & q_ff.frm_rdy;

  // post-tag type/len is classified and registered one cycle before keys start
  aclks_classify u_classify (
    .clock_i    (clock_i),
    .sys_rst_i  (sys_rst_i),
    .take_i     (take),
    .etype_i    (frm_etype_i),
    .ip_ver_i   (frm_ip_ver_i),
    .dip_msb_i  (frm_dip_msb_i),
    .proto_i    (frm_proto_i),
    .dsap_i     (frm_dsap_i),
    .ssap_i     (frm_ssap_i),
    .llc_ctrl_i (frm_llc_ctrl_i),
    .valid_o    (cls_valid),
    .ftype_o    (cls_ftype),
    .l4_o       (cls_l4)
  );

  // selections not offered for the frame type fall back to the generic key
  function automatic logic [2:0] resolve_key(aclks_pkg::aclks_ftype_t ft, logic [2:0] sel);
    logic ok;
    ok = 1'b0;
    case (ft)
      aclks_pkg::FT_IPV6_MC: ok = sel inside {aclks_pkg::KEY_IPV6_VLAN, aclks_pkg::KEY_SEVEN_TUPLE};
      aclks_pkg::FT_IPV6_UC: ok = sel == aclks_pkg::KEY_SEVEN_TUPLE;
      aclks_pkg::FT_IPV4_MC: ok = sel inside {aclks_pkg::KEY_IPV4_VLAN, aclks_pkg::KEY_SEVEN_TUPLE,
                                              aclks_pkg::KEY_IPV4_L4, aclks_pkg::KEY_IPV4_MISC};
      aclks_pkg::FT_IPV4_UC: ok = sel inside {aclks_pkg::KEY_SEVEN_TUPLE, aclks_pkg::KEY_IPV4_L4,
                                              aclks_pkg::KEY_IPV4_MISC};
      aclks_pkg::FT_ARP:     ok = sel == aclks_pkg::KEY_ARP;
      default:               ok = 1'b0;
    endcase
    return ok ? sel : aclks_pkg::KEY_GENERIC_L2;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    nxt_q   = q_ff;
    wa      = q_ff.aw_addr;
    ra      = s_axi_araddr;
    wword   = 32'h0000_0000;
    rword   = 32'h0000_0000;
    rhit    = 1'b1;
    nxt_q.key_vld = 1'b0;
    nxt_q.act_vld = 1'b0;

    // register writes: address and data taken in either order, then committed together
    if (s_axi_awvalid && q_ff.aw_rdy) begin
      nxt_q.aw_have = 1'b1;
      nxt_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_ff.w_rdy) begin
      nxt_q.w_have = 1'b1;
      nxt_q.w_data = s_axi_wdata;
      nxt_q.w_strb = s_axi_wstrb;
    end
    if (q_ff.bvalid && s_axi_bready) begin
      nxt_q.bvalid = 1'b0;
    end
    if (q_ff.aw_have && q_ff.w_have && !q_ff.bvalid) begin
      nxt_q.aw_have = 1'b0;
      nxt_q.w_have  = 1'b0;
      nxt_q.bvalid  = 1'b1;
      nxt_q.bresp   = aclks_pkg::RESP_OKAY;
      if (wa[11:6] == aclks_pkg::A_ENA_BASE[11:6]) begin
        wword = merge({28'h0000000, q_ff.ena[wa[5:2]]}, q_ff.w_data, q_ff.w_strb);
        nxt_q.ena[wa[5:2]] = wword[aclks_pkg::NLKP-1:0];
      end else if (wa[11:6] == aclks_pkg::A_KSEL_BASE[11:6]) begin
        for (int l = 0; l < aclks_pkg::NLKP; l++) begin
          wword[l*aclks_pkg::KSEL_FW +: 3] = q_ff.ksel[wa[5:2]][l];
        end
        wword = merge(wword, q_ff.w_data, q_ff.w_strb);
        for (int l = 0; l < aclks_pkg::NLKP; l++) begin
          nxt_q.ksel[wa[5:2]][l] = wword[l*aclks_pkg::KSEL_FW +: 3];
        end
      end else if (wa[11:4] == aclks_pkg::A_DEF_BASE[11:4]) begin
        wword = merge({16'h0000, q_ff.def_act[wa[3:2]]}, q_ff.w_data, q_ff.w_strb);
        nxt_q.def_act[wa[3:2]] = wword[aclks_pkg::ACTW-1:0];
      end else if (wa[11:4] == aclks_pkg::A_HIT_BASE[11:4]) begin
        // any write clears; a same-cycle count still adds on top
        nxt_q.hits[wa[3:2]] = '0;
      end else if (wa[11:4] == aclks_pkg::A_MISS_BASE[11:4]) begin
        nxt_q.miss[wa[3:2]] = '0;
      end else if (wa[11:2] != aclks_pkg::A_STATUS[11:2]) begin
        nxt_q.bresp = aclks_pkg::RESP_SLVERR;
      end
    end
    nxt_q.aw_rdy = !nxt_q.aw_have;
    nxt_q.w_rdy  = !nxt_q.w_have;

    // register reads
    if (ra[11:6] == aclks_pkg::A_ENA_BASE[11:6]) begin
      rword = {28'h0000000, q_ff.ena[ra[5:2]]};
    end else if (ra[11:6] == aclks_pkg::A_KSEL_BASE[11:6]) begin
      for (int l = 0; l < aclks_pkg::NLKP; l++) begin
        rword[l*aclks_pkg::KSEL_FW +: 3] = q_ff.ksel[ra[5:2]][l];
      end
    end else if (ra[11:4] == aclks_pkg::A_DEF_BASE[11:4]) begin
      rword = {16'h0000, q_ff.def_act[ra[3:2]]};
    end else if (ra[11:4] == aclks_pkg::A_HIT_BASE[11:4]) begin
      rword = q_ff.hits[ra[3:2]];
    end else if (ra[11:4] == aclks_pkg::A_MISS_BASE[11:4]) begin
      rword = q_ff.miss[ra[3:2]];
    end else if (ra[11:2] == aclks_pkg::A_STATUS[11:2]) begin
      rword = {20'h00000, q_ff.st != ST_IDLE, q_ff.lkp, q_ff.l4, 3'h0, q_ff.ftype};
    end else begin
      rhit = 1'b0;
    end
    if (q_ff.rvalid && s_axi_rready) begin
      nxt_q.rvalid = 1'b0;
      nxt_q.ar_rdy = 1'b1;
    end
    if (s_axi_arvalid && q_ff.ar_rdy) begin
      nxt_q.ar_rdy = 1'b0;
      nxt_q.rvalid = 1'b1;
      nxt_q.rdata  = rword;
      nxt_q.rresp  = rhit ? aclks_pkg::RESP_OKAY : aclks_pkg::RESP_SLVERR;
    end

    // lookup sequencing
    case (q_ff.st)
      ST_IDLE: begin
        if (take) begin
          nxt_q.frm_rdy = 1'b0;
          nxt_q.port    = frm_port_i;
          nxt_q.cust    = frm_custom_i;
          nxt_q.ofs     = frm_custom_ofs_i;
          nxt_q.st      = ST_CLASS;
        end
      end
      ST_CLASS: begin
        if (cls_valid) begin
          nxt_q.ftype = cls_ftype;
          nxt_q.l4    = cls_l4;
          nxt_q.lkp   = '0;
          nxt_q.st    = ST_KEY;
        end
      end
      ST_KEY: begin
        if (q_ff.ena[q_ff.port][q_ff.lkp]) begin
          nxt_q.key_vld  = 1'b1;
          nxt_q.key_type = q_ff.cust ? aclks_pkg::KEY_CUSTOM
                                     : resolve_key(q_ff.ftype, q_ff.ksel[q_ff.port][q_ff.lkp]);
          nxt_q.st       = ST_WAIT;
        end else if (q_ff.lkp == 2'(aclks_pkg::NLKP - 1)) begin
          nxt_q.st      = ST_IDLE;
          nxt_q.frm_rdy = 1'b1;
        end else begin
          nxt_q.lkp = q_ff.lkp + 2'h1;
        end
      end
      ST_WAIT: begin
        if (res_valid_i) begin
          nxt_q.act_vld = 1'b1;
          nxt_q.act_hit = res_hit_i;
          nxt_q.act_lkp = q_ff.lkp;
          nxt_q.act     = res_hit_i ? res_action_i : q_ff.def_act[q_ff.lkp];
          if (res_hit_i) begin
            nxt_q.hits[q_ff.lkp] = nxt_q.hits[q_ff.lkp] + 32'h1;
          end else begin
            nxt_q.miss[q_ff.lkp] = nxt_q.miss[q_ff.lkp] + 32'h1;
          end
          if (q_ff.lkp == 2'(aclks_pkg::NLKP - 1)) begin
            nxt_q.st      = ST_IDLE;
            nxt_q.frm_rdy = 1'b1;
          end else begin
            nxt_q.lkp = q_ff.lkp + 2'h1;
            nxt_q.st  = ST_KEY;
          end
        end
      end
      default: begin
        nxt_q.st      = ST_IDLE;
        nxt_q.frm_rdy = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      q_ff          <= '0;
      q_ff.st       <= ST_IDLE;
      q_ff.ftype    <= aclks_pkg::FT_ETYPE;
      q_ff.l4       <= aclks_pkg::L4_OTHER;
      q_ff.frm_rdy  <= 1'b1;
      q_ff.aw_rdy   <= 1'b1;
      q_ff.w_rdy    <= 1'b1;
      q_ff.ar_rdy   <= 1'b1;
      q_ff.ena      <= {aclks_pkg::NPORT{aclks_pkg::ENA_RST}};
      q_ff.ksel     <= {(aclks_pkg::NPORT * aclks_pkg::NLKP){aclks_pkg::KSEL_RST}};
      q_ff.def_act  <= {aclks_pkg::NLKP{aclks_pkg::DEF_ACT_RST}};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign frm_ready_o      = q_ff.frm_rdy;
  assign key_valid_o      = q_ff.key_vld;
  assign key_lookup_o     = q_ff.lkp;
  assign key_type_o       = q_ff.key_type;
  assign key_frame_type_o = q_ff.ftype;
  assign key_l4_o         = q_ff.l4;
  assign key_port_o       = q_ff.port;
  assign key_custom_ofs_o = q_ff.ofs;
  assign act_valid_o      = q_ff.act_vld;
  assign act_lookup_o     = q_ff.act_lkp;
  assign act_hit_o        = q_ff.act_hit;
  assign act_action_o     = q_ff.act;
  assign s_axi_awready    = q_ff.aw_rdy;
  assign s_axi_wready     = q_ff.w_rdy;
  assign s_axi_bresp      = q_ff.bresp;
  assign s_axi_bvalid     = q_ff.bvalid;
  assign s_axi_arready    = q_ff.ar_rdy;
  assign s_axi_rdata      = q_ff.rdata;
  assign s_axi_rresp      = q_ff.rresp;
  assign s_axi_rvalid     = q_ff.rvalid;

endmodule

// >>> test/aclks_match_model.sv
`timescale 1ns/100ps
// match table stand-in: answers a key after dly_i + 1 idle cycles, odd lookups hit
module aclks_match_model (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       key_valid_i,
  input  wire logic [1:0] key_lookup_i,
  input  wire logic [2:0] key_type_i,
  output logic            res_valid_o,
  output logic            res_hit_o,
  output logic [15:0]     res_action_o
);
  logic       pend;
  logic [3:0] cnt;
  logic [4:0] tag;
  always @(posedge clock_i) begin
    res_valid_o <= 1'b0;
    // idle lines toggle so a stale value never passes as an answer
    res_hit_o <= ~res_hit_o;
    res_action_o <= ~res_action_o;
    if (sys_rst_i) begin
      pend <= 1'b0;
      res_hit_o <= 1'b0;
      res_action_o <= 16'h0000;
    end else if (key_valid_i) begin
      pend <= 1'b1;
      cnt <= dly_i;
      tag <= {key_type_i, key_lookup_i};
    end else if (pend && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (pend) begin
      pend <= 1'b0;
      res_valid_o <= 1'b1;
      res_hit_o <= tag[0];
      res_action_o <= {8'hc0, 3'h0, tag};
    end
  end
endmodule

// >>> test/aclks_top_properties.sv
`timescale 1ns/100ps
module aclks_top_checker (
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic        frm_valid_i,
  input wire logic        frm_ready_o,
  input wire logic        key_valid_o,
  input wire logic [2:0]  key_type_o,
  input wire logic [3:0]  key_frame_type_o,
  input wire logic        res_valid_i,
  input wire logic        res_hit_i,
  input wire logic [15:0] res_action_i,
  input wire logic        act_valid_o,
  input wire logic [1:0]  act_lookup_o,
  input wire logic        act_hit_o,
  input wire logic [15:0] act_action_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_take; frm_valid_i && frm_ready_o; endsequence
  // a result only counts while a frame is in flight
  sequence s_res; res_valid_i && !frm_ready_o; endsequence
  property p_take_busy; s_take |=> !frm_ready_o; endproperty
  a_take_busy: assert property (p_take_busy) else $error("ready stayed high after a take");
  property p_key_in_frame; key_valid_o |-> !frm_ready_o && key_frame_type_o <= 4'h8; endproperty
  a_key_in_frame: assert property (p_key_in_frame) else $error("key outside frame or bad type");
  property p_generic_only; key_valid_o && key_frame_type_o >= 4'h5 && key_type_o != 3'h7 |-> key_type_o == 3'h0;
  endproperty
  a_generic_only: assert property (p_generic_only) else $error("non-ip frame got a non-generic key");
  property p_v6uc_keys; key_valid_o && key_frame_type_o == 4'h1 |-> key_type_o inside {3'h0, 3'h2, 3'h7}; endproperty
  a_v6uc_keys: assert property (p_v6uc_keys) else $error("ipv6 unicast got a foreign key");
  property p_key_gap; key_valid_o |=> !key_valid_o [*2]; endproperty
  a_key_gap: assert property (p_key_gap) else $error("keys closer than a result round trip");
  property p_act_from_res; s_res |=> act_valid_o && act_hit_o == $past(res_hit_i); endproperty
  a_act_from_res: assert property (p_act_from_res) else $error("result not turned into an action");
  property p_hit_action; act_valid_o && act_hit_o |-> act_action_o == $past(res_action_i); endproperty
  a_hit_action: assert property (p_hit_action) else $error("hit action not the entry action");
  property p_last_done; act_valid_o && act_lookup_o == 2'h3 |-> frm_ready_o; endproperty
  a_last_done: assert property (p_last_done) else $error("not ready after last lookup");
endmodule
bind aclks_top aclks_top_checker i_props (.*);

// >>> test/aclks_top_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module aclks_top_tb;
  logic        clock_i, sys_rst_i, frm_valid_i, frm_ready_o, frm_custom_i, key_valid_o, res_valid_i, res_hit_i;
  logic        act_valid_o, act_hit_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  key_lookup_o, key_l4_o, act_lookup_o, s_axi_bresp, s_axi_rresp;
  logic [2:0]  key_type_o;
  logic [3:0]  frm_port_i, frm_ip_ver_i, key_frame_type_o, key_port_o, s_axi_wstrb, dly;
  logic [7:0]  frm_dip_msb_i, frm_proto_i, frm_dsap_i, frm_ssap_i, frm_llc_ctrl_i, frm_custom_ofs_i, key_custom_ofs_o;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [15:0] frm_etype_i, res_action_i, act_action_o;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          num_errors, comparisons, hits [4], miss [4];
  // {type/len, version, dip top byte, protocol, dsap, ssap, control, expected frame type}
  localparam logic [63:0] FTAB [15] = '{64'h86dd6ff060000000, 64'h86dd620110000001, 64'h08004e0010000002,
    64'h080040a060000003, 64'h0806000000000004, 64'h8035000000000004, 64'h8902000000000005, 64'h004000000aaaa036,
    64'h004000000aaaa027, 64'h05ff00000aaab037, 64'h0600000000000008, 64'h86dd400000000008, 64'h08004ef110000002,
    64'h08004df110000003, 64'h86dd6fe3a0000001};
  aclks_top i_dut (.*);
  aclks_match_model i_tbl (.clock_i, .sys_rst_i, .dly_i(dly), .key_valid_i(key_valid_o), .key_lookup_i(key_lookup_o),
    .key_type_i(key_type_o), .res_valid_o(res_valid_i), .res_hit_o(res_hit_i), .res_action_o(res_action_i));
  function automatic logic [2:0] kexp(input logic [3:0] ft, input logic [2:0] s);
    case (ft)
      4'h0: return (s inside {3'h1, 3'h2}) ? s : 3'h0;
      4'h1: return (s == 3'h2) ? s : 3'h0;
      4'h2: return (s inside {[3'h2:3'h5]}) ? s : 3'h0;
      4'h3: return (s inside {[3'h2:3'h4]}) ? s : 3'h0;
      4'h4: return (s == 3'h6) ? s : 3'h0;
      default: return 3'h0;
    endcase
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    @(posedge clock_i);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    {aw, w} = '0;
    while (!(aw && w)) begin
      @(posedge clock_i);
      if (s_axi_awvalid && s_axi_awready) begin aw = 1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wvalid && s_axi_wready) begin w = 1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge clock_i); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock_i);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge clock_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock_i); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
  endtask
  task automatic frame(input logic [3:0] p, input logic [63:0] f, input logic cu, input logic [3:0] en,
                       input logic [15:0] sel);
    int cyc, nk;
    logic [2:0] ek;
    @(posedge clock_i);
    {frm_etype_i, frm_ip_ver_i, frm_dip_msb_i, frm_proto_i, frm_dsap_i, frm_ssap_i, frm_llc_ctrl_i} <= f[63:4];
    {frm_port_i, frm_custom_i, frm_custom_ofs_i, frm_valid_i} <= {p, cu, 8'h2c, 1'b1};
    dly <= dly ^ 4'h5;
    do @(posedge clock_i); while (!frm_ready_o);
    frm_valid_i <= 1'b0;
    cyc = 0;
    nk = 0;
    do begin
      @(posedge clock_i);
      cyc++;
      if (key_valid_o) begin
        nk++;
        ek = cu ? 3'h7 : kexp(f[3:0], sel[4*key_lookup_o +: 3]);
        `CHK(key_type_o, ek)
        `CHK(key_frame_type_o, f[3:0])
        `CHK(key_port_o, p)
        if (f[3:0] < 4'h4) `CHK(key_l4_o, f[35:28] == 8'h06 ? 2'h0 : f[35:28] == 8'h11 ? 2'h1 : 2'h2)
        if (cu) `CHK(key_custom_ofs_o, 8'h2c)
      end
      if (act_valid_o) begin
        `CHK(act_hit_o, act_lookup_o[0])
        `CHK(act_action_o, act_lookup_o[0] ? {8'hc0, 3'h0, ek, act_lookup_o} : 16'hd000 + act_lookup_o)
        if (act_lookup_o[0]) hits[act_lookup_o]++; else miss[act_lookup_o]++;
      end
    end while (!frm_ready_o && cyc < 300);
    `CHK(frm_ready_o, 1'b1)
    `CHK(nk, $countones(en))
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clock_i = 0;
    forever #12.5 clock_i = ~clock_i;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    summarize;
  end
  initial begin
    {frm_valid_i, frm_custom_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    dly = '0;
    sys_rst_i = 1'b1;
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(aclks_pkg::A_ENA_BASE + 12'hc, 0, aclks_pkg::RESP_OKAY);
    rd(aclks_pkg::A_KSEL_BASE + 12'hc, 0, aclks_pkg::RESP_OKAY);
    rd(12'hffc, 0, aclks_pkg::RESP_SLVERR);
    wr(12'hffc, 32'h1, aclks_pkg::RESP_SLVERR);
    for (int i = 0; i < 4; i++) wr(aclks_pkg::A_DEF_BASE + 12'(4 * i), 32'hd000 + i, aclks_pkg::RESP_OKAY);
    wr(aclks_pkg::A_ENA_BASE + 12'hc, 32'hf, aclks_pkg::RESP_OKAY);
    wr(aclks_pkg::A_KSEL_BASE + 12'hc, 32'h6312, aclks_pkg::RESP_OKAY);
    wr(aclks_pkg::A_ENA_BASE + 12'h14, 32'hc, aclks_pkg::RESP_OKAY);
    wr(aclks_pkg::A_KSEL_BASE + 12'h14, 32'h4500, aclks_pkg::RESP_OKAY);
    $display("test registers done");
    for (int i = 0; i < 15; i++) frame(4'h3, FTAB[i], 1'b0, 4'hf, 16'h6312);
    frame(4'h3, FTAB[1], 1'b1, 4'hf, 16'h6312);
    frame(4'h5, FTAB[2], 1'b0, 4'hc, 16'h4500);
    frame(4'h5, FTAB[3], 1'b0, 4'hc, 16'h4500);
    frame(4'h0, FTAB[3], 1'b0, 4'h0, 16'h0000);
    $display("test frames done");
    rd(aclks_pkg::A_STATUS, 32'h603, aclks_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      rd(aclks_pkg::A_HIT_BASE + 12'(4 * i), 32'(hits[i]), aclks_pkg::RESP_OKAY);
      rd(aclks_pkg::A_MISS_BASE + 12'(4 * i), 32'(miss[i]), aclks_pkg::RESP_OKAY);
    end
    wr(aclks_pkg::A_HIT_BASE + 12'h4, 32'h0, aclks_pkg::RESP_OKAY);
    rd(aclks_pkg::A_HIT_BASE + 12'h4, 32'h0, aclks_pkg::RESP_OKAY);
    $display("test statistics done");
    summarize;
  end
endmodule
